//--- rtl/die_link_initiator.v
/*
 * Die link initiator: APB register slave, a minimal serial transfer engine,
 * the low power drain and park sequence, and the two interrupt requests.
 * Assumes the CPU wait and stop levels come from logic on pclk, and that
 * the link inputs from the companion die are asynchronous.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
// How it works
// (RULE1) Wait without stop-in-wait behaves like run.
// (RULE2) Wait with stop-in-wait drains the pending transfer.
// (RULE3) Then park link clock low, stop engine.
// (RULE4) Stop mode parks regardless of stop-in-wait.
// (RULE5) Reset aborts transfer and disables the block.
// (RULE6) Interrupts only while interrupt enable is set; the error request ignores it.
// (RULE7) Separate target and error interrupt outputs.
// (RULE8) Target interrupt level follows input, active high.
// (RULE9) Target holds its line until its clear.
// (RULE10) Status 1 shows the target interrupt level.
// (RULE11) Target interrupt still passes while parked.
// (RULE12) Error request holds until one written.
// (RULE13) Error request has no local mask.
// (RULE14) Software sets width, divider, timeout first.
// (RULE15) Blocking mode write acknowledged before sleeping.
// (RULE16) Target sleeps only after acknowledging mode write.
// (RULE17) Target wakes regulator, then raises interrupt.
// (RULE18) Clock generation restarts before servicing wake.
// (RULE19) Link clock ends high phase, stays low.
// (RULE20) Disabled: registers live, core idle, pins released.
// (RULE21) Error set: buffers frozen, transfers become idle.
// (RULE22) Restart link clock from low after wake.
`timescale 1ns/1ns
`include "die_link_defs.vh"
module die_link_initiator #(
    parameter DIVW = 8,
    parameter TOW  = 8
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        cpu_wait,
    input  wire        cpu_stop,
    input  wire        target_irq_in,
    input  wire        link_data_in,
    input  wire        link_ack_in,
    input  wire        link_err_in,
    output reg         link_clock_out,
    output reg         link_data_out,
    output reg         link_data_oe,
    output reg         gpio_mode,
    output reg         target_irq_signal,
    output reg         link_error_irq,
    output reg         lowpower_parked
);

    // ************************************************************
    // State codes
    // ************************************************************
    localparam [1:0] LP_RUN   = 2'd0;
    localparam [1:0] LP_DRAIN = 2'd1;
    localparam [1:0] LP_PARK  = 2'd2;
    localparam [1:0] TX_IDLE  = 2'd0;
    localparam [1:0] TX_SHIFT = 2'd1;
    localparam [1:0] TX_ACK   = 2'd2;
    localparam [1:0] TX_ALIGN = 2'd3;

    // ************************************************************
    // Registers and wires
    // ************************************************************
    reg  [3:0]      ctl0_q;
    reg  [DIVW-1:0] div_q;
    reg  [TOW-1:0]  timeout_q;
    reg             err_q;
    reg             timef_q;
    reg             terr_q;
    reg             cancel_q;
    reg  [7:0]      addr_buf_q;
    reg  [15:0]     data_buf_q;
    reg  [1:0]      lp_q;
    reg  [1:0]      tx_q;
    reg  [23:0]     shift_q;
    reg  [4:0]      bits_q;
    reg  [TOW-1:0]  wait_q;
    reg             read_q;
    reg             wide_q;
    wire [3:0]      sync_w;
    wire            clk_w;
    wire            rise_w;
    wire            fall_w;
    wire            parked_w;
    wire            setup_w;
    wire            wr_w;
    wire            busy_w;
    wire            enabled_w;
    wire            lp_req_w;
    wire            launch_w;
    reg  [31:0]     rd_d;
    reg             bad_d;

    assign setup_w   = psel && !penable;
    assign wr_w      = setup_w && pwrite;
    assign enabled_w = ctl0_q[`CTL0_ENABLE];
    assign busy_w    = (tx_q != TX_IDLE);
    // Stop forces the park path, wait only with stop-in-wait. [RULE1] [RULE4]
    assign lp_req_w  = enabled_w && (cpu_stop || (cpu_wait && ctl0_q[`CTL0_SWAI]));
    // New transfers start only in run with the error flag clear. [RULE21] [RULE22]
    assign launch_w  = wr_w && (paddr == `OFS_COMMAND) && enabled_w && !err_q
                       && !busy_w && (lp_q == LP_RUN);

    // ************************************************************
    // Input synchronisers and link clock
    // ************************************************************
    link_sync #(
        .WIDTH    (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({link_err_in, link_ack_in, link_data_in, target_irq_in}),
        .sync_q   (sync_w)
    );

    // Parking waits until the engine is idle, then the high phase ends. [RULE2] [RULE19]
    link_clk_gen #(
        .DIVW     (DIVW)
    ) u_clk (
        .pclk     (pclk),
        .presetn  (presetn),
        .run_en   (enabled_w),
        .stop_req (lp_q != LP_RUN && !busy_w),
        .div      (div_q),
        .clk_q    (clk_w),
        .rise_q   (rise_w),
        .fall_q   (fall_w),
        .parked   (parked_w)
    );

    // ************************************************************
    // Register read decode
    // ************************************************************
    always @* begin
        rd_d  = 32'h0000_0000;
        bad_d = 1'b0;
        case (paddr)
            `OFS_CONTROL_0: rd_d[3:0] = ctl0_q;
            `OFS_CONTROL_1: rd_d[DIVW+TOW-1:0] = {timeout_q, div_q};
            `OFS_STATUS_0:  rd_d[4:0] = {busy_w, cancel_q, terr_q, timef_q, err_q};
            // Live target line level, no latching. [RULE10]
            `OFS_STATUS_1:  rd_d[1:0] = {lp_q == LP_PARK, sync_w[0]};
            `OFS_COMMAND:   rd_d = 32'h0000_0000;
            `OFS_ADDR_BUF:  rd_d[7:0] = addr_buf_q;
            `OFS_DATA_BUF:  rd_d[15:0] = data_buf_q;
            default:        bad_d = 1'b1;
        endcase
    end

    // ************************************************************
    // APB slave: answers in the first access cycle
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_w;
            pslverr <= setup_w && bad_d;
            if (setup_w && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_q    <= `CTL0_RESET; // [RULE5]
            div_q     <= `DIV_RESET;
            timeout_q <= `TIMEOUT_RESET;
        end else if (wr_w) begin
            if (paddr == `OFS_CONTROL_0) begin
                // Enable is write once; only reset clears it again.
                ctl0_q <= {pwdata[3:1], pwdata[`CTL0_ENABLE] | enabled_w};
            end
            // Timing setup is locked once enabled, so a live link is not retimed. [RULE14]
            if (paddr == `OFS_CONTROL_1 && !enabled_w) begin
                div_q     <= pwdata[DIVW-1:0];
                timeout_q <= pwdata[DIVW+TOW-1:DIVW];
            end
        end
    end

    // ************************************************************
    // Low power sequence
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_q <= LP_RUN;
        end else begin
            case (lp_q)
                LP_RUN: begin
                    if (lp_req_w) begin
                        lp_q <= LP_DRAIN; // [RULE2] [RULE4]
                    end
                end
                LP_DRAIN: begin
                    if (!busy_w && parked_w) begin
                        lp_q <= LP_PARK; // [RULE3] [RULE19]
                    end
                end
                LP_PARK: begin
                    // A wake simply releases the divider, which restarts low. [RULE18] [RULE22]
                    if (!lp_req_w) begin
                        lp_q <= LP_RUN;
                    end
                end
                default: lp_q <= LP_RUN;
            endcase
        end
    end

    // ************************************************************
    // Transfer engine
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q       <= TX_IDLE; // [RULE5]
            shift_q    <= 24'h00_0000;
            bits_q     <= 5'd0;
            wait_q     <= {TOW{1'b0}};
            read_q     <= 1'b0;
            wide_q     <= 1'b0;
            addr_buf_q <= 8'h00;
            data_buf_q <= 16'h0000;
            err_q      <= 1'b0;
            timef_q    <= 1'b0;
            terr_q     <= 1'b0;
            cancel_q   <= 1'b0;
        end else begin
            // One written to the error flag clears every error source at once. [RULE12]
            if (wr_w && paddr == `OFS_STATUS_0 && pwdata[`STAT0_ERR]) begin
                err_q    <= 1'b0;
                timef_q  <= 1'b0;
                terr_q   <= 1'b0;
                cancel_q <= 1'b0;
            end
            // A request refused while in error is replaced by idle and marked. [RULE21]
            if (wr_w && paddr == `OFS_COMMAND && err_q) begin
                cancel_q <= 1'b1;
            end
            case (tx_q)
                TX_IDLE: begin
                    if (launch_w) begin
                        read_q     <= pwdata[`CMD_READ];
                        wide_q     <= ctl0_q[`CTL0_WIDE];
                        addr_buf_q <= pwdata[7:0];
                        data_buf_q <= pwdata[23:8];
                        shift_q    <= ctl0_q[`CTL0_WIDE] ? {pwdata[7:0], pwdata[23:8]}
                                                          : {pwdata[7:0], pwdata[15:8], 8'h00};
                        bits_q     <= `ADDR_BITS + (ctl0_q[`CTL0_WIDE] ? `WIDE_BITS
                                                                        : `NARROW_BITS);
                        tx_q       <= TX_ALIGN;
                    end
                end
                TX_ALIGN: begin
                    // Start on a fall, so the first bit gets a full low phase before its rise.
                    if (fall_w) begin
                        tx_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (fall_w) begin
                        shift_q <= {shift_q[22:0], 1'b0};
                        bits_q  <= bits_q - 5'd1;
                        if (bits_q == 5'd1) begin
                            wait_q <= {TOW{1'b0}};
                            tx_q   <= TX_ACK;
                        end
                    end
                    if (rise_w && read_q && bits_q <= (wide_q ? `WIDE_BITS : `NARROW_BITS)) begin
                        data_buf_q <= {data_buf_q[14:0], sync_w[1]};
                    end
                end
                TX_ACK: begin
                    if (rise_w) begin
                        wait_q <= wait_q + 1'b1;
                        if (sync_w[2]) begin // [RULE15]
                            tx_q <= TX_IDLE;
                            if (sync_w[3]) begin
                                err_q  <= 1'b1;
                                terr_q <= 1'b1;
                            end
                        end else if (wait_q == timeout_q) begin
                            tx_q    <= TX_IDLE;
                            err_q   <= 1'b1;
                            timef_q <= 1'b1;
                        end
                    end
                end
                default: tx_q <= TX_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Pins and interrupt requests
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_clock_out    <= 1'b0;
            link_data_out     <= 1'b0;
            link_data_oe      <= 1'b0;
            gpio_mode         <= 1'b1;
            target_irq_signal <= 1'b0;
            link_error_irq    <= 1'b0;
            lowpower_parked   <= 1'b0;
        end else begin
            link_clock_out  <= clk_w; // [RULE19]
            link_data_out   <= (tx_q == TX_SHIFT) && shift_q[23];
            link_data_oe    <= enabled_w && (tx_q == TX_SHIFT) && (!read_q || bits_q > 
                               (wide_q ? `WIDE_BITS : `NARROW_BITS));
            gpio_mode       <= !enabled_w; // [RULE20]
            lowpower_parked <= (lp_q == LP_PARK); // [RULE3]
            // This flop runs on the free bus clock, so it still wakes a parked CPU. [RULE11]
            target_irq_signal <= enabled_w && ctl0_q[`CTL0_IRQ_EN] && sync_w[0]; // [RULE6] [RULE7] [RULE8]
            // The error request ignores the interrupt enable bit. [RULE13] [RULE7]
            link_error_irq  <= enabled_w && err_q;
        end
    end
endmodule // die_link_initiator

//--- rtl/die_link_defs.vh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * die link initiator.
 * Assumes it is included by bare name from the rtl folder, definitions only.
 */
`ifndef DIE_LINK_DEFS_VH
`define DIE_LINK_DEFS_VH

// ************************************************************
// Register byte offsets on the bus
// ************************************************************
`define OFS_CONTROL_0     12'h000
`define OFS_CONTROL_1     12'h004
`define OFS_STATUS_0      12'h008
`define OFS_STATUS_1      12'h00C
`define OFS_COMMAND       12'h010
`define OFS_ADDR_BUF      12'h014
`define OFS_DATA_BUF      12'h018

// ************************************************************
// Field positions
// ************************************************************
`define CTL0_ENABLE       0
`define CTL0_IRQ_EN       1
`define CTL0_SWAI         2
`define CTL0_WIDE         3
`define STAT0_ERR         0
`define STAT0_TIMEOUT     1
`define STAT0_TERR        2
`define STAT0_CANCEL      3
`define STAT0_BUSY        4
`define STAT1_IRQ_LEVEL   0
`define STAT1_PARKED      1
`define CMD_READ          24

// ************************************************************
// Reset values and frame figures
// ************************************************************
`define CTL0_RESET        4'h0
`define DIV_RESET         8'h01
`define TIMEOUT_RESET     8'h10
`define ADDR_BITS         5'd8
`define NARROW_BITS       5'd8
`define WIDE_BITS         5'd16

`endif

//--- rtl/link_sync.v
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level; no bit relation is preserved.
 */
`timescale 1ns/1ns
module link_sync #(
    parameter WIDTH = 4
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_q
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule // link_sync

//--- rtl/link_clk_gen.v
/*
 * Link clock divider. Each half period lasts div+1 bus clock cycles.
 * Assumes stop_req is a level from the bus clock domain; while it stands the
 * clock finishes its high phase and then parks low.
 */
`timescale 1ns/1ns
module link_clk_gen #(
    parameter DIVW = 8
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire            run_en,
    input  wire            stop_req,
    input  wire [DIVW-1:0] div,
    output reg             clk_q,
    output reg             rise_q,
    output reg             fall_q,
    output wire            parked
);
    reg [DIVW-1:0] cnt_q;

    // A stop request is only declared parked once the clock has settled low; a cleared run enable parks at once.
    assign parked = !run_en || (stop_req && !clk_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= {DIVW{1'b0}};
            clk_q  <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            if (parked) begin
                // Restart always begins with a full low phase.
                cnt_q <= {DIVW{1'b0}};
                clk_q <= 1'b0;
            end else if (cnt_q == div) begin
                cnt_q  <= {DIVW{1'b0}};
                clk_q  <= !clk_q;
                rise_q <= !clk_q;
                fall_q <= clk_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // link_clk_gen

//--- verification/die_link_initiator_checker.sv
/* Checker for the die link initiator: bus answer, interrupt levels, park.
   Assumes a bind to the initiator and a single domain on pclk. */
`timescale 1ns/1ns
`include "die_link_defs.vh"
module die_link_initiator_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        cpu_wait,
    input wire        cpu_stop,
    input wire        target_irq_in,
    input wire        link_clock_out,
    input wire        link_data_oe,
    input wire        gpio_mode,
    input wire        target_irq_signal,
    input wire        link_error_irq,
    input wire        lowpower_parked
);
    // ********
    // Helpers
    // ********
    wire clr_w;
    assign clr_w = psel && !penable && pwrite && paddr == `OFS_STATUS_0 && pwdata[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_park;
        $rose(lowpower_parked);
    endsequence
    sequence s_unpark;
        $fell(lowpower_parked);
    endsequence
    sequence s_irq_quiet;
        !target_irq_in [*4];
    endsequence
    a_bus_answer: assert property (psel && !penable |=> pready)
        else $error("bus setup got no answer");
    a_error_holds: assert property (
        link_error_irq && !clr_w && !$past(clr_w) |=> link_error_irq)
        else $error("error request dropped without clear");
    a_error_clears: assert property (clr_w |-> ##[1:3] !link_error_irq)
        else $error("error request stayed after clear");
    a_irq_rise: assert property ($rose(target_irq_signal) |-> $past(target_irq_in, 2))
        else $error("target request rose without input");
    a_irq_fall: assert property (s_irq_quiet |-> !target_irq_signal)
        else $error("target request high with input low");
    a_gpio_quiet: assert property (gpio_mode |-> !link_data_oe && !link_clock_out)
        else $error("link driven while disabled");
    a_park_low: assert property (lowpower_parked |-> !link_clock_out && !link_data_oe)
        else $error("link active while parked");
    a_park_entry: assert property (s_park |-> $past(cpu_wait || cpu_stop))
        else $error("parked without a low power request");
    a_wake_low: assert property (s_unpark |-> !link_clock_out)
        else $error("link clock not low on wake");
    a_run_unpark: assert property ((!cpu_wait && !cpu_stop) [*3] |-> !lowpower_parked)
        else $error("still parked in run mode");
endmodule // die_link_initiator_checker

bind die_link_initiator die_link_initiator_checker u_checker (.*);

//--- verification/link_target_model.sv
/* Behavioural model of the companion die holding the link target.
   Assumes the bench drives its knobs on pclk. */
`timescale 1ns/1ns
module link_target_model (
    input  wire pclk,
    input  wire link_clock_out,
    input  wire link_data_out,
    input  wire link_data_oe,
    input  wire ack_en,
    input  wire err_en,
    input  wire slow,
    input  wire wake,
    input  wire sleep,
    input  wire irq_clear,
    output wire target_irq_in,
    output wire link_data_in,
    output wire link_ack_in,
    output wire link_err_in,
    output reg  [23:0] rx_q
);
    reg [3:0] rise_q = 4'h0;
    reg       lp_q   = 1'b0;
    reg       irq_q  = 1'b0;
    always @(posedge pclk) begin
        if (sleep && !wake) lp_q <= 1'b1;
        if (wake) lp_q <= 1'b0;
        if (wake && !lp_q) irq_q <= 1'b1;
        else if (irq_clear) irq_q <= 1'b0;
    end
    always @(posedge link_clock_out) begin
        rise_q <= link_data_oe ? 4'h0 : rise_q + 4'h1;
        if (link_data_oe) rx_q <= {rx_q[22:0], link_data_out};
    end
    assign link_ack_in   = ack_en && (!slow || rise_q > 4'h2);
    assign link_err_in   = err_en;
    assign target_irq_in = irq_q;
    // Read data is the parity of the rises after the address, 0101 MSB first.
    assign link_data_in  = rise_q[0];
endmodule // link_target_model

//--- verification/die_link_initiator_tb.sv
/* Testbench for the die link initiator with a target model on the link.
   Assumes the rtl folder on the include path. */
`timescale 1ns/1ns
`include "die_link_defs.vh"
module die_link_initiator_tb;
    logic        pclk, presetn, psel, penable, pwrite, cpu_wait, cpu_stop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic        pready, pslverr, serr_q, link_clock_out, link_data_out;
    logic        link_data_oe, gpio_mode, target_irq_signal, link_error_irq;
    logic        lowpower_parked, ack_en, err_en, slow, wake, sleep, irq_clear;
    wire         target_irq_in, link_data_in, link_ack_in, link_err_in;
    wire [23:0]  rx_q;
    int          err_total, samples_checked, k;

    die_link_initiator i_dut (.*);
    link_target_model i_target (.*);

    // ********
    // Tasks
    // ********
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        rd_q = prdata;
        serr_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) err_total++;
    endtask
    task automatic rd(input logic [11:0] a, input string n, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, rd_q, e);
    endtask
    // The wait is bounded; a hung transfer shows up as a mismatch.
    task automatic idle;
        repeat (120) begin
            bus(1'b0, `OFS_STATUS_0, 32'h0);
            if (rd_q[`STAT0_BUSY] === 1'b0) return;
        end
        err_total++;
    endtask
    task automatic park_wait(input logic e);
        int n;
        for (n = 0; n < 400 && lowpower_parked !== e; n++) @(posedge pclk);
        chk("parked", 32'(lowpower_parked), 32'(e));
    endtask
    task automatic mode(input logic w, input logic s);
        @(posedge pclk);
        cpu_wait <= w;
        cpu_stop <= s;
        sleep <= w | s;
    endtask
    task automatic tgt(input logic w, input logic c);
        @(posedge pclk);
        wake <= w;
        irq_clear <= c;
        sleep <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #2000000;
        err_total++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, cpu_wait, cpu_stop} = '0;
        {paddr, pwdata} = '0;
        {ack_en, err_en, slow, wake, sleep, irq_clear} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("gpio", 32'(gpio_mode), 32'h1);
        rd(`OFS_CONTROL_0, "ctl0", 32'h0);
        rd(`OFS_CONTROL_1, "ctl1", 32'h0000_1001);
        rd(12'h020, "unmapped", 32'h0);
        chk("slverr", 32'(serr_q), 32'h1);
        tgt(1'b1, 1'b0);
        rd(`OFS_STATUS_1, "irq_level", 32'h1);
        chk("irq_disabled", 32'(target_irq_signal), 32'h0);
        bus(1'b1, `OFS_COMMAND, 32'h0000_A555);
        rd(`OFS_STATUS_0, "cmd_disabled", 32'h0);
        $display("test disabled done");
        bus(1'b1, `OFS_CONTROL_1, 32'h0000_1003);
        bus(1'b1, `OFS_CONTROL_0, 32'h1);
        repeat (4) @(posedge pclk);
        chk("gpio_on", 32'(gpio_mode), 32'h0);
        chk("irq_masked", 32'(target_irq_signal), 32'h0);
        bus(1'b1, `OFS_CONTROL_0, 32'h3);
        repeat (4) @(posedge pclk);
        chk("irq_on", 32'(target_irq_signal), 32'h1);
        tgt(1'b0, 1'b1);
        chk("irq_off", 32'(target_irq_signal), 32'h0);
        $display("test interrupt done");
        ack_en <= 1'b1;
        slow <= 1'b1;
        mode(1'b1, 1'b0);
        bus(1'b1, `OFS_COMMAND, 32'h0000_A555);
        idle;
        rd(`OFS_STATUS_0, "wait_run", 32'h0);
        rd(`OFS_ADDR_BUF, "addr_buf", 32'h55);
        chk("frame", 32'(rx_q[15:0]), 32'h55A5);
        chk("no_park", 32'(lowpower_parked), 32'h0);
        mode(1'b0, 1'b0);
        $display("test wait_run done");
        bus(1'b1, `OFS_CONTROL_0, 32'h7);
        bus(1'b1, `OFS_COMMAND, 32'h0000_3C11);
        mode(1'b1, 1'b0);
        rd(`OFS_STATUS_0, "drain_busy", 32'h10);
        park_wait(1'b1);
        rd(`OFS_STATUS_0, "drained", 32'h0);
        chk("clk_low", 32'(link_clock_out), 32'h0);
        repeat (20) @(posedge pclk);
        chk("clk_stays_low", 32'(link_clock_out), 32'h0);
        rd(`OFS_STATUS_1, "park_status", 32'h2);
        tgt(1'b1, 1'b0);
        chk("wake_irq", 32'(target_irq_signal), 32'h1);
        rd(`OFS_STATUS_1, "wake_status", 32'h3);
        mode(1'b0, 1'b0);
        park_wait(1'b0);
        tgt(1'b0, 1'b1);
        bus(1'b1, `OFS_COMMAND, 32'h0100_5A21);
        idle;
        rd(`OFS_STATUS_0, "after_wake", 32'h0);
        rd(`OFS_DATA_BUF, "read_data", 32'h5A55);
        chk("read_addr", 32'(rx_q[7:0]), 32'h21);
        $display("test park done");
        bus(1'b1, `OFS_CONTROL_0, 32'hB);
        mode(1'b0, 1'b1);
        park_wait(1'b1);
        mode(1'b0, 1'b0);
        park_wait(1'b0);
        bus(1'b1, `OFS_COMMAND, 32'h0012_3442);
        idle;
        chk("wide_frame", 32'(rx_q), 32'h0042_1234);
        $display("test stop done");
        bus(1'b1, `OFS_CONTROL_0, 32'h1);
        slow <= 1'b0;
        for (k = 0; k < 2; k++) begin
            @(posedge pclk);
            ack_en <= k[0];
            err_en <= k[0];
            bus(1'b1, `OFS_COMMAND, 32'h0000_0042 + k);
            idle;
            rd(`OFS_STATUS_0, "err_flags", k ? 32'h5 : 32'h3);
            chk("err_irq", 32'(link_error_irq), 32'h1);
            bus(1'b1, `OFS_COMMAND, 32'h0000_0077);
            rd(`OFS_STATUS_0, "cancel", k ? 32'hD : 32'hB);
            rd(`OFS_ADDR_BUF, "addr_frozen", 32'h42 + k);
            bus(1'b1, `OFS_STATUS_0, 32'h1);
            rd(`OFS_STATUS_0, "err_clear", 32'h0);
            chk("err_irq_off", 32'(link_error_irq), 32'h0);
        end
        $display("test errors done");
        err_en <= 1'b0;
        bus(1'b1, `OFS_COMMAND, 32'h0000_1234);
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("abort_oe", 32'(link_data_oe), 32'h0);
        chk("abort_gpio", 32'(gpio_mode), 32'h1);
        presetn <= 1'b1;
        rd(`OFS_CONTROL_0, "ctl0_again", 32'h0);
        rd(`OFS_STATUS_0, "stat0_again", 32'h0);
        $display("test reset done");
        end_of_test;
    end
endmodule // die_link_initiator_tb
